// ---- include/fescm_pkg.sv ----
`default_nettype none
package fescm_pkg;
	// Command codes
	localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
	localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
	localparam logic [7:0] CMD_UNSECURE = 8'h0B;
	localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
	localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
	// Final word index expected at launch
	localparam logic [2:0] IDX_0 = 3'h0;
	localparam logic [2:0] IDX_1 = 3'h1;
	localparam logic [2:0] IDX_4 = 3'h4;
	localparam int IDX_W = 3;
	localparam int NWORDS = 5;
	// Margin settings
	localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
	localparam logic [15:0] MARGIN_USER1 = 16'h0001;
	localparam logic [15:0] MARGIN_USER0 = 16'h0002;
	localparam logic [1:0] BACKDOOR_ON = 2'h2;
	// Register byte offsets
	localparam logic [7:0] OFS_INDEX = 8'h00;
	localparam logic [7:0] OFS_WORD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CONFIG = 8'h0C;
	localparam logic [7:0] OFS_KEY_LO = 8'h10;
	localparam logic [7:0] OFS_KEY_HI = 8'h14;
	localparam logic [7:0] OFS_ARRAY = 8'h18;
	localparam logic [7:0] OFS_MARGIN = 8'h1C;
	// Status bit positions
	localparam int ST_CC = 7;
	localparam int ST_ACC = 5;
	localparam int ST_PV = 4;
	localparam int ST_VE = 1;
	localparam int ST_VU = 0;
	// Config bit positions
	localparam int CF_MODE_OK = 0;
	localparam int CF_PROT_P = 1;
	localparam int CF_PROT_D = 2;
	localparam int CF_KEY_LO = 4;
	localparam int CF_BLK_VALID_LO = 8;
	localparam logic [1:0] PFLASH_BLK = 2'h0;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0F01;
	localparam int BUSY_CYCLES = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic ve;
		logic vu;
	} fescm_verify_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} fescm_state_e;
endpackage
`default_nettype wire

// ---- src/fescm_top.sv ----
// Overview of operation
// R1 - Code 09 with block bits 17:16 erases a whole block.
// R2 - Block erase access error: index not 001, invalid block, misaligned address.
// R3 - Any command here flags access error when not allowed in current mode.
// R4 - Block erase flags protection violation if the block has protection.
// R5 - Verify errors set verify flag; uncorrectable ones set uncorrectable flag.
// R6 - Software writes code 0A plus block at index 0, sector address at index 1.
// R7 - Launch erases and verifies the sector, then sets command complete.
// R8 - Sector erase access error: index not 001, invalid block, address bits 2:0 nonzero.
// R9 - Sector erase flags protection violation on a protected sector.
// R10 - Unsecure is code 0B; access error unless index is 000.
// R11 - Unsecure erases all, verifies; security released only on good verify.
// R12 - Unsecure flags protection violation if any region is protected.
// R13 - Software writes no register while unsecure runs.
// R14 - Backdoor key is code 0C plus four keys; final index must be 100.
// R15 - Key check runs only when backdoor enable field is 10.
// R16 - Four keys compared in order; match releases security, then complete.
// R17 - After mismatch, later key checks abort with access error until reset.
// R18 - Software must not run key check from the key-holding block.
// R19 - Margin command 0D sets block read level, then command complete.
// R20 - Margin 0000 normal, 0001 user margin-1, 0002 user margin-0.
// R21 - D-flash margin affects D only; P-flash margin affects both.
// R22 - Margin-1 leans to erased state, margin-0 to programmed state.
`default_nettype none
module fescm_top #(
	parameter int BUSY = fescm_pkg::BUSY_CYCLES
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic secure, // device secured
	output logic [1:0] p_margin, // level for P-flash reads
	output logic [1:0] d_margin // level for D-flash reads
);
	initial
	begin
		if (BUSY < 1 || BUSY > 65535)
			$error("BUSY out of range");
	end

	logic [fescm_pkg::IDX_W-1:0] command_word_index;
	logic [15:0] command_parameter_words [fescm_pkg::NWORDS];
	logic command_complete_flag, access_error_flag, protection_violation_flag;
	logic verify_error_flag, verify_uncorrectable_flag;
	logic [31:0] config_reg;
	logic [31:0] key_lo, key_hi;
	fescm_pkg::fescm_verify_s array_result;
	logic key_failed;
	fescm_pkg::fescm_state_e state;
	logic [15:0] busy_cnt;
	logic [7:0] cmd_q;
	logic [1:0] margin_p, margin_d;

	// Write channel: address and data taken in either order
	logic aw_held, w_held;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic do_write;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fescm_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q > fescm_pkg::OFS_MARGIN || aw_q[1:0] != 2'h0)
					? fescm_pkg::RESP_SLVERR : fescm_pkg::RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Write decode; the launch is a 1 written to the complete bit while it is set
	logic wr_index, wr_word, wr_status, wr_config, wr_klo, wr_khi, wr_array, launch;
	always_comb
	begin
		wr_index = do_write && aw_q == fescm_pkg::OFS_INDEX && ws_q[0];
		wr_word = do_write && aw_q == fescm_pkg::OFS_WORD;
		wr_status = do_write && aw_q == fescm_pkg::OFS_STATUS && ws_q[0];
		wr_config = do_write && aw_q == fescm_pkg::OFS_CONFIG;
		wr_klo = do_write && aw_q == fescm_pkg::OFS_KEY_LO;
		wr_khi = do_write && aw_q == fescm_pkg::OFS_KEY_HI;
		wr_array = do_write && aw_q == fescm_pkg::OFS_ARRAY && ws_q[0];
		launch = wr_status && w_q[fescm_pkg::ST_CC] && command_complete_flag;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			command_word_index <= '0;
		else if (wr_index && command_complete_flag)
			command_word_index <= w_q[fescm_pkg::IDX_W-1:0];
	end

	genvar gi;
	generate
		for (gi = 0; gi < fescm_pkg::NWORDS; gi++)
		begin : g_word
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					command_parameter_words[gi] <= 16'h0000;
				else if (wr_word && command_complete_flag && command_word_index == gi)
				begin
					if (ws_q[0])
						command_parameter_words[gi][7:0] <= w_q[7:0];
					if (ws_q[1])
						command_parameter_words[gi][15:8] <= w_q[15:8];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			config_reg <= fescm_pkg::CONFIG_RESET;
			key_lo <= 32'h0000_0000;
			key_hi <= 32'h0000_0000;
			array_result <= '0;
		end
		else
		begin
			if (wr_config)
				config_reg <= w_q;
			if (wr_klo)
				key_lo <= w_q;
			if (wr_khi)
				key_hi <= w_q;
			if (wr_array)
				array_result <= fescm_pkg::fescm_verify_s'(w_q[1:0]);
		end
	end

	// Launch checks
	logic [7:0] cmd;
	logic [1:0] blk;
	logic blk_ok, mode_ok, any_prot, blk_prot, bad_idx, bad_addr, acc, pv, key_ok;
	logic [15:0] w1;
	always_comb
	begin
		cmd = command_parameter_words[0][15:8];
		blk = command_parameter_words[0][1:0];
		w1 = command_parameter_words[1];
		blk_ok = config_reg[fescm_pkg::CF_BLK_VALID_LO + 32'(blk)];
		mode_ok = config_reg[fescm_pkg::CF_MODE_OK]; // [R3]
		any_prot = config_reg[fescm_pkg::CF_PROT_P] | config_reg[fescm_pkg::CF_PROT_D];
		blk_prot = (blk == fescm_pkg::PFLASH_BLK) ? config_reg[fescm_pkg::CF_PROT_P]
			: config_reg[fescm_pkg::CF_PROT_D];
		key_ok = {command_parameter_words[2], command_parameter_words[1]} == key_lo
			&& {command_parameter_words[4], command_parameter_words[3]} == key_hi; // [R16]
		bad_idx = 1'b0;
		bad_addr = 1'b0;
		pv = 1'b0;
		case (cmd)
			fescm_pkg::CMD_ERASE_BLOCK: // [R1]
			begin
				bad_idx = command_word_index != fescm_pkg::IDX_1; // [R2]
				// P-flash phrase aligned, D-flash word aligned [R2]
				bad_addr = !blk_ok || ((blk == fescm_pkg::PFLASH_BLK) ? (w1[2:0] != 3'h0)
					: w1[0]);
				pv = blk_prot; // [R4]
			end
			fescm_pkg::CMD_ERASE_SECTOR:
			begin
				bad_idx = command_word_index != fescm_pkg::IDX_1; // [R8]
				bad_addr = !blk_ok || w1[2:0] != 3'h0; // [R8]
				pv = blk_prot; // [R9]
			end
			fescm_pkg::CMD_UNSECURE:
			begin
				bad_idx = command_word_index != fescm_pkg::IDX_0; // [R10]
				pv = any_prot; // [R12]
			end
			fescm_pkg::CMD_BACKDOOR:
			begin
				bad_idx = command_word_index != fescm_pkg::IDX_4; // [R14]
				// [R15] [R17]
				bad_addr = config_reg[fescm_pkg::CF_KEY_LO +: 2] != fescm_pkg::BACKDOOR_ON
					|| key_failed;
			end
			fescm_pkg::CMD_USER_MARGIN:
			begin
				bad_idx = command_word_index != fescm_pkg::IDX_1;
				bad_addr = !blk_ok || (w1 != fescm_pkg::MARGIN_NORMAL
					&& w1 != fescm_pkg::MARGIN_USER1 && w1 != fescm_pkg::MARGIN_USER0);
			end
			default: bad_idx = 1'b1;
		endcase
		acc = bad_idx || bad_addr || !mode_ok;
	end

	// Sequencer: erases run for BUSY cycles; errors end the command at once
	logic busy_end;
	assign busy_end = busy_cnt == 16'(BUSY - 1);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= fescm_pkg::ST_IDLE;
			busy_cnt <= 16'h0000;
			cmd_q <= 8'h00;
		end
		else
		begin
			case (state)
				fescm_pkg::ST_IDLE:
					if (launch)
					begin
						cmd_q <= cmd;
						busy_cnt <= 16'h0000;
						state <= (acc || pv) ? fescm_pkg::ST_DONE : fescm_pkg::ST_BUSY;
					end
				fescm_pkg::ST_BUSY:
				begin
					busy_cnt <= busy_cnt + 16'h0001;
					if (busy_end)
						state <= fescm_pkg::ST_DONE;
				end
				fescm_pkg::ST_DONE:
					state <= fescm_pkg::ST_IDLE;
				default:
					state <= fescm_pkg::ST_IDLE;
			endcase
		end
	end

	logic erase_cmd, finish;
	assign erase_cmd = cmd_q == fescm_pkg::CMD_ERASE_BLOCK
		|| cmd_q == fescm_pkg::CMD_ERASE_SECTOR || cmd_q == fescm_pkg::CMD_UNSECURE;
	assign finish = state == fescm_pkg::ST_BUSY && busy_end;

	// Complete flag drops at launch and rises when the command ends [R7] [R19]
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			command_complete_flag <= 1'b1;
		else if (launch)
			command_complete_flag <= 1'b0;
		else if (state == fescm_pkg::ST_DONE)
			command_complete_flag <= 1'b1;
	end

	// Access error and protection flags: writing 1 clears, but a new error in the same cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			access_error_flag <= 1'b0;
			protection_violation_flag <= 1'b0;
			verify_error_flag <= 1'b0;
			verify_uncorrectable_flag <= 1'b0;
		end
		else
		begin
			if (launch)
			begin
				access_error_flag <= acc; // [R2] [R3] [R8] [R10] [R14] [R15] [R17]
				protection_violation_flag <= !acc && pv; // [R4] [R9] [R12]
				verify_error_flag <= 1'b0;
				verify_uncorrectable_flag <= 1'b0;
			end
			else if (wr_status)
			begin
				if (w_q[fescm_pkg::ST_ACC])
					access_error_flag <= 1'b0;
				if (w_q[fescm_pkg::ST_PV])
					protection_violation_flag <= 1'b0;
			end
			if (finish && erase_cmd)
			begin
				verify_error_flag <= array_result.ve; // [R5] [R11]
				verify_uncorrectable_flag <= array_result.vu; // [R5]
			end
			// A wrong key is itself an access error, later tries are locked out
			if (finish && cmd_q == fescm_pkg::CMD_BACKDOOR && !key_ok)
				access_error_flag <= 1'b1; // [R17]
		end
	end

	// Security, key lockout and margin levels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			secure <= 1'b1;
			key_failed <= 1'b0;
			margin_p <= 2'h0;
			margin_d <= 2'h0;
		end
		else if (finish)
		begin
			// Release needs a clean verify [R11]
			if (cmd_q == fescm_pkg::CMD_UNSECURE && !array_result.ve)
				secure <= 1'b0;
			if (cmd_q == fescm_pkg::CMD_BACKDOOR)
			begin
				if (key_ok)
					secure <= 1'b0; // [R16]
				else
					key_failed <= 1'b1; // [R17]
			end
			if (cmd_q == fescm_pkg::CMD_USER_MARGIN)
			begin
				// P-flash level also steers D-flash reads [R21] [R19] [R20]
				if (blk == fescm_pkg::PFLASH_BLK)
					margin_p <= w1[1:0];
				margin_d <= w1[1:0];
			end
		end
	end
	// Level 1 reads toward erased, level 2 toward programmed [R22]
	assign p_margin = margin_p;
	assign d_margin = margin_d;

	// Read channel
	logic [31:0] rd;
	always_comb
	begin
		rd = 32'h0000_0000;
		case (s_axi_araddr)
			fescm_pkg::OFS_INDEX: rd[fescm_pkg::IDX_W-1:0] = command_word_index;
			fescm_pkg::OFS_WORD: rd[15:0] = command_parameter_words[command_word_index
				< 3'(fescm_pkg::NWORDS) ? command_word_index : 3'h0];
			fescm_pkg::OFS_STATUS:
			begin
				rd[fescm_pkg::ST_CC] = command_complete_flag;
				rd[fescm_pkg::ST_ACC] = access_error_flag;
				rd[fescm_pkg::ST_PV] = protection_violation_flag;
				rd[fescm_pkg::ST_VE] = verify_error_flag;
				rd[fescm_pkg::ST_VU] = verify_uncorrectable_flag;
			end
			fescm_pkg::OFS_CONFIG: rd = config_reg;
			fescm_pkg::OFS_KEY_LO: rd = key_lo;
			fescm_pkg::OFS_KEY_HI: rd = key_hi;
			fescm_pkg::OFS_ARRAY: rd[1:0] = array_result;
			fescm_pkg::OFS_MARGIN: rd[4:0] = {!secure, margin_d, margin_p};
			default: rd = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= fescm_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd;
				s_axi_rresp <= (s_axi_araddr > fescm_pkg::OFS_MARGIN || s_axi_araddr[1:0] != 2'h0)
					? fescm_pkg::RESP_SLVERR : fescm_pkg::RESP_OKAY;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	AST_LAUNCH_DROPS_CC: assert property (@(posedge aclk) disable iff (!aresetn)
		launch |=> !command_complete_flag) else $error("complete flag not cleared"); // [R7]
	AST_ACC_ENDS_FAST: assert property (@(posedge aclk) disable iff (!aresetn)
		launch && acc |=> ##1 command_complete_flag && access_error_flag)
		else $error("error launch did not finish"); // [R3]
	AST_KEY_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		launch && cmd == fescm_pkg::CMD_BACKDOOR && key_failed |=> access_error_flag)
		else $error("locked key check ran"); // [R17]
	AST_PV_NO_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
		launch && pv && !acc |=> protection_violation_flag && state == fescm_pkg::ST_DONE)
		else $error("protected erase ran"); // [R12]
	AST_SECURE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		finish && cmd_q == fescm_pkg::CMD_UNSECURE && array_result.ve |=> secure == $past(secure))
		else $error("security released on bad verify"); // [R11]
	AST_VERIFY_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		finish && erase_cmd |=> verify_error_flag == $past(array_result.ve))
		else $error("verify flag wrong"); // [R5]
	AST_SECTOR_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn)
		launch && cmd == fescm_pkg::CMD_ERASE_SECTOR && w1[2:0] != 3'h0 |=> access_error_flag)
		else $error("misaligned sector accepted"); // [R8]
	AST_BLOCK_IDX: assert property (@(posedge aclk) disable iff (!aresetn)
		launch && cmd == fescm_pkg::CMD_ERASE_BLOCK && command_word_index != fescm_pkg::IDX_1
		|=> access_error_flag) else $error("bad index accepted"); // [R2]
endmodule // fescm_top
`default_nettype wire

// ---- sim/fescm_sw_model.sv ----
`default_nettype none
// Software side: sole AXI4-Lite master, runs from RAM, never from the key block
module fescm_sw_model (
	input wire logic aclk, // clock
	output logic [7:0] s_axi_awaddr, // write address
	output logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	output logic [31:0] s_axi_wdata, // write data
	output logic [3:0] s_axi_wstrb, // write strobes
	output logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic s_axi_bvalid, // write response valid
	output logic s_axi_bready, // write response ready
	output logic [7:0] s_axi_araddr, // read address
	output logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_rvalid, // read data valid
	output logic s_axi_rready // read data ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int n_stuck;
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		n_stuck = 0;
	end
	// The leading edge keeps a new request off the edge that ended the last one
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid && n < 200);
		s_axi_bready <= 1'h0;
		if (n >= 200)
			n_stuck++;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid && n < 200);
		s_axi_rready <= 1'h0;
		if (n >= 200)
			n_stuck++;
	endtask
endmodule // fescm_sw_model
`default_nettype wire

// ---- sim/fescm_tb_top.sv ----
`default_nettype none
module fescm_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BUSY = 4;
	localparam logic [31:0] CFG = 32'h0000_0F01;
	localparam logic [7:0] EB = fescm_pkg::CMD_ERASE_BLOCK;
	localparam logic [7:0] ES = fescm_pkg::CMD_ERASE_SECTOR;
	localparam logic [7:0] UN = fescm_pkg::CMD_UNSECURE;
	localparam logic [7:0] BD = fescm_pkg::CMD_BACKDOOR;
	localparam logic [7:0] UM = fescm_pkg::CMD_USER_MARGIN;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, secure;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, p_margin, d_margin;
	logic [31:0] q_exp[$], q_mask[$];
	logic [1:0] q_resp[$];
	logic [15:0] kw[1:4], k[0:3], sa;
	int n_mismatch, num_checks;
	fescm_top #(.BUSY(BUSY)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .secure(secure),
		.p_margin(p_margin), .d_margin(d_margin));
	fescm_sw_model sw (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	initial
	begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		check("stuck", 32'(sw.n_stuck), 32'h0);
		check("pending", 32'(q_exp.size()), 32'h0);
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Read results are compared here, in the order the reads were issued
	always @(posedge aclk)
		if (aresetn && s_axi_rvalid && s_axi_rready && q_exp.size() > 0)
		begin
			check("rdata", s_axi_rdata & q_mask.pop_front(), q_exp.pop_front());
			check("rresp", {30'h0, s_axi_rresp}, {30'h0, q_resp.pop_front()});
		end
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r);
		q_exp.push_back(e & m);
		q_mask.push_back(m);
		q_resp.push_back(r);
		sw.rd(a);
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
	endtask
	task automatic ports(input logic s, input logic [1:0] p, input logic [1:0] d);
		check("secure", {31'h0, secure}, {31'h0, s});
		check("p_margin", {30'h0, p_margin}, {30'h0, p});
		check("d_margin", {30'h0, d_margin}, {30'h0, d});
	endtask
	// st is {access error, protection, verify, uncorrectable}
	task automatic run(input logic [7:0] code, input logic [1:0] blk, input logic [2:0] last,
		input logic [15:0] w1, input logic [31:0] cfg, input logic [1:0] inj,
		input logic [3:0] st);
		kw[1] = w1;
		sw.wr(fescm_pkg::OFS_CONFIG, cfg);
		sw.wr(fescm_pkg::OFS_ARRAY, {30'h0, inj});
		sw.wr(fescm_pkg::OFS_INDEX, 32'h0);
		sw.wr(fescm_pkg::OFS_WORD, {16'h0, code, 6'h0, blk});
		for (int i = 1; i <= last; i++)
		begin
			sw.wr(fescm_pkg::OFS_INDEX, 32'(i));
			sw.wr(fescm_pkg::OFS_WORD, {16'h0, kw[i]});
		end
		sw.wr(fescm_pkg::OFS_STATUS, 32'h80);
		// No register access while a command runs
		repeat (BUSY + 6) @(posedge aclk);
		expect_rd(fescm_pkg::OFS_STATUS, {24'h0, 2'h2, st[3:2], 2'h0, st[1:0]}, 32'hB3, 2'h0);
		sw.wr(fescm_pkg::OFS_STATUS, 32'h30);
	endtask
	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		aresetn = 1'h0;
		n_mismatch = 0;
		num_checks = 0;
		void'($urandom(32'hB741));
		for (int i = 0; i < 4; i++)
			k[i] = 16'($urandom());
		sa = 16'($urandom()) & 16'hFFF8;
		{kw[2], kw[3], kw[4]} = {k[1], k[2], k[3]};
		do_reset();
		expect_rd(fescm_pkg::OFS_STATUS, 32'h80, 32'hB3, 2'h0);
		expect_rd(fescm_pkg::OFS_CONFIG, CFG, 32'h0F37, 2'h0);
		ports(1'h1, 2'h0, 2'h0);
		sw.wr(8'h20, 32'h0);
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, fescm_pkg::RESP_SLVERR});
		expect_rd(8'h02, 32'h0, 32'h0, fescm_pkg::RESP_SLVERR);
		$display("test reset_and_bus done");
		for (int c = 9; c <= 13; c++)
			run(8'(c), 2'h0, (c == 11) ? 3'h0 : (c == 12) ? 3'h4 : 3'h1, 16'h0, 32'h0F00, 2'h0, 4'h8);
		run(EB, 2'h0, 3'h0, 16'h0, CFG, 2'h0, 4'h8);
		run(EB, 2'h2, 3'h1, 16'h0, 32'h0301, 2'h0, 4'h8);
		run(EB, 2'h0, 3'h1, 16'h0004, CFG, 2'h0, 4'h8);
		run(EB, 2'h1, 3'h1, 16'h0001, CFG, 2'h0, 4'h8);
		run(EB, 2'h1, 3'h1, 16'h0002, CFG, 2'h0, 4'h0);
		run(EB, 2'h0, 3'h1, 16'h0, 32'h0F03, 2'h0, 4'h4);
		run(EB, 2'h1, 3'h1, 16'h0, 32'h0F05, 2'h0, 4'h4);
		run(EB, 2'h0, 3'h1, 16'h0, CFG, 2'h2, 4'h2);
		run(EB, 2'h0, 3'h1, 16'h0, CFG, 2'h3, 4'h3);
		$display("test block_erase done");
		run(ES, 2'h0, 3'h0, sa, CFG, 2'h0, 4'h8);
		run(ES, 2'h0, 3'h1, sa | 16'h0004, CFG, 2'h0, 4'h8);
		run(ES, 2'h2, 3'h1, sa, 32'h0301, 2'h0, 4'h8);
		run(ES, 2'h0, 3'h1, sa, 32'h0F03, 2'h0, 4'h4);
		run(ES, 2'h0, 3'h1, sa, CFG, 2'h0, 4'h0);
		$display("test sector_erase done");
		run(UN, 2'h0, 3'h1, 16'h0, CFG, 2'h0, 4'h8);
		run(UN, 2'h0, 3'h0, 16'h0, 32'h0F05, 2'h0, 4'h4);
		run(UN, 2'h0, 3'h0, 16'h0, CFG, 2'h2, 4'h2);
		ports(1'h1, 2'h0, 2'h0);
		run(UN, 2'h0, 3'h0, 16'h0, CFG, 2'h0, 4'h0);
		ports(1'h0, 2'h0, 2'h0);
		$display("test unsecure done");
		for (int j = 0; j < 3; j++)
		begin
			do_reset();
			sw.wr(fescm_pkg::OFS_KEY_LO, {k[1], k[0]});
			sw.wr(fescm_pkg::OFS_KEY_HI, {k[3], k[2]});
			kw[4] = (j == 1) ? ~k[3] : k[3];
			run(BD, 2'h0, 3'h3, k[0], 32'h0F21, 2'h0, 4'h8);
			run(BD, 2'h0, 3'h4, k[0], CFG, 2'h0, 4'h8);
			run(BD, 2'h0, 3'h4, k[0], 32'h0F21, 2'h0, (j == 1) ? 4'h8 : 4'h0);
			kw[4] = k[3];
			if (j == 1)
				run(BD, 2'h0, 3'h4, k[0], 32'h0F21, 2'h0, 4'h8);
			ports(j == 1, 2'h0, 2'h0);
		end
		$display("test backdoor done");
		run(UM, 2'h1, 3'h1, fescm_pkg::MARGIN_USER1, CFG, 2'h0, 4'h0);
		ports(1'h0, 2'h0, 2'h1);
		expect_rd(fescm_pkg::OFS_MARGIN, 32'h14, 32'h1F, 2'h0);
		run(UM, 2'h0, 3'h1, fescm_pkg::MARGIN_USER0, CFG, 2'h0, 4'h0);
		ports(1'h0, 2'h2, 2'h2);
		run(UM, 2'h0, 3'h1, 16'h0003, CFG, 2'h0, 4'h8);
		run(UM, 2'h0, 3'h0, 16'h0, CFG, 2'h0, 4'h8);
		ports(1'h0, 2'h2, 2'h2);
		run(UM, 2'h0, 3'h1, fescm_pkg::MARGIN_NORMAL, CFG, 2'h0, 4'h0);
		ports(1'h0, 2'h0, 2'h0);
		$display("test margin done");
		print_verdict();
	end
endmodule // fescm_tb_top
`default_nettype wire
